// ### pkg/fpv_pkg.sv
// shared constants and types for the flash protect and verify block
package fpv_pkg;

  // clock and prewrite-verify settling time
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned PVV_SETTLE_US = 4;
  localparam int unsigned PVV_SETTLE_RAW =
    (PVV_SETTLE_US * CLK_HZ + 999_999) / 1_000_000;
  localparam logic [7:0] PVV_SETTLE_CYC = 8'(PVV_SETTLE_RAW);

  // apb register byte offsets
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] ADDR_MODE = 12'h000;
  localparam logic [11:0] ADDR_BLK1 = 12'h004;
  localparam logic [11:0] ADDR_BLK2 = 12'h008;
  localparam logic [11:0] ADDR_STAT = 12'h00C;

  // mode control register fields
  localparam int unsigned MODE_P_BIT = 0;
  localparam int unsigned MODE_E_BIT = 1;
  localparam int unsigned MODE_PV_BIT = 2;
  localparam int unsigned MODE_EV_BIT = 3;
  localparam logic [7:0] MODE_WMASK = 8'h0F;

  // status register fields
  localparam int unsigned STAT_LVL_LSB = 0;
  localparam int unsigned STAT_PROG_BIT = 3;
  localparam int unsigned STAT_ERASE_BIT = 4;
  localparam int unsigned STAT_HWP_BIT = 5;
  localparam int unsigned STAT_RDY_BIT = 6;

  // reset values
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] BLK1_RST = 8'h00;
  localparam logic [7:0] BLK2_RST = 8'h00;

  // block layout: four large blocks in register one, eight small in two
  localparam int unsigned BLK1_USED = 4;
  localparam int unsigned NUM_BLOCKS = 12;
  localparam logic [7:0] ALL_PROT_BLK1 = 8'hF0;
  localparam logic [7:0] ALL_PROT_BLK2 = 8'h00;

  // voltage level applied to the cells
  typedef enum logic [2:0] {
    LVL_READ = 3'b000,
    LVL_PREWRITE = 3'b001,
    LVL_PV = 3'b010,
    LVL_EV = 3'b011,
    LVL_PROG = 3'b100,
    LVL_ERASE = 3'b101
  } fpv_level_t;

  // apb request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } fpv_apb_req_t;

  // hardware protection sources
  typedef struct packed {
    logic vpp_ok;
    logic low_power;
    logic wdt_reset;
  } fpv_prot_in_t;

endpackage : fpv_pkg

// ### verilog/fpv_mode_dec.sv
// decodes mode bits and block selects into cell level and block enables
`timescale 1ns/1ps
`default_nettype none
module fpv_mode_dec import fpv_pkg::*; (
  input wire logic [3:0] mode_bits,
  input wire logic [11:0] blk_en,
  input wire logic hw_prot,
  output fpv_level_t level,
  output logic [11:0] prog_blk,
  output logic [11:0] erase_blk
);

  // p wins over e, then the verify bits; all clear gives prewrite-verify
  always_comb begin
    level = LVL_READ;
    prog_blk = '0;
    erase_blk = '0;
    if (hw_prot) begin
      level = LVL_READ;
    end else if (mode_bits[MODE_P_BIT]) begin
      level = LVL_PROG;
      prog_blk = blk_en;
    end else if (mode_bits[MODE_E_BIT]) begin
      level = LVL_ERASE;
      erase_blk = blk_en;
    end else if (mode_bits[MODE_PV_BIT]) begin
      level = LVL_PV;
    end else if (mode_bits[MODE_EV_BIT]) begin
      level = LVL_EV;
    end else begin
      level = LVL_PREWRITE;
    end
  end

endmodule : fpv_mode_dec
`default_nettype wire

// ### verilog/fpv_settle_tmr.sv
// counts the settling time after prewrite-verify is selected
`timescale 1ns/1ps
`default_nettype none
module fpv_settle_tmr import fpv_pkg::*; (
  input wire logic clk,
  input wire logic resetn,
  input wire logic active,
  output logic ready
);

  typedef struct packed {
    logic [7:0] cnt;
  } fpv_tmr_t;

  fpv_tmr_t q, d;

  // restart from zero whenever the mode is left, saturate at the count
  always_comb begin
    d = q;
    if (!active) begin
      d.cnt = 8'h00;
    end else if (q.cnt != PVV_SETTLE_CYC) begin
      d.cnt = q.cnt + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign ready = active && (q.cnt == PVV_SETTLE_CYC);

  settle_early_a: assert property (@(posedge clk) disable iff (!resetn)
    $rose(ready) |-> $past(active, 159) && $past(active))
    else $error("settle flag rose before full wait");
  settle_drop_a: assert property (@(posedge clk) disable iff (!resetn)
    !active |-> !ready)
    else $error("settle flag high outside prewrite-verify");

endmodule : fpv_settle_tmr
`default_nettype wire

// ### verilog/fpv_flash_protect.sv
// flash protection and prewrite-verify control with apb registers
//
// Function
// - all mode bits clear selects prewrite-verify
// - prewrite-verify level applied, read returns data
// - protected blocks get no program or erase enable; the level still switches
// - per-block protect; verify modes stay usable
// - select values F0 and 00 protect all
// - hardware protection stops work, clears registers
// - no programming voltage clears and disables all
// - reset or low power clears and disables
// - hardware protection erase-disables every block
`timescale 1ns/1ps
`default_nettype none
module fpv_flash_protect import fpv_pkg::*; (
  input wire logic clk,
  input wire logic resetn,
  input wire fpv_apb_req_t apb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire fpv_prot_in_t prot,
  input wire logic flash_rd_req,
  input wire logic [7:0] flash_cell_data,
  output logic [7:0] rd_data,
  output fpv_level_t cell_level,
  output logic [11:0] prog_blk,
  output logic [11:0] erase_blk,
  output logic hw_protect,
  output logic pvv_ready
);

  // all block state
  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] blk1;
    logic [7:0] blk2;
    logic [7:0] rd_data;
    logic [31:0] prdata;
    logic slverr;
    logic ack;
  } fpv_regs_t;

  fpv_regs_t q, d;
  logic hw_prot;
  logic [11:0] blk_en;
  fpv_level_t level;
  logic [11:0] prog_mask;
  logic [11:0] erase_mask;
  logic settled;
  logic acc;
  logic wr_acc;
  logic hit;
  logic [31:0] rd_word;
  logic [7:0] stat;

  // any hardware protection source, all synchronous inputs
  // no synchroniser here: the sources must already be in this clock domain
  assign hw_prot = !prot.vpp_ok | prot.low_power | prot.wdt_reset;

  // only the low bits of register one name real blocks
  // its upper nibble is still stored so software reads back what it wrote
  assign blk_en = {q.blk2, q.blk1[BLK1_USED-1:0]};

  // purely combinational, so a protect edge drops the enables at once
  fpv_mode_dec u_dec (
    .mode_bits(q.mode[3:0]),
    .blk_en(blk_en),
    .hw_prot(hw_prot),
    .level(level),
    .prog_blk(prog_mask),
    .erase_blk(erase_mask)
  );

  // settle count restarts whenever the level leaves prewrite-verify
  fpv_settle_tmr u_tmr (
    .clk(clk),
    .resetn(resetn),
    .active(level == LVL_PREWRITE),
    .ready(settled)
  );

  // apb access phase; two cycles so read data can come from a flop
  // the price is one wait state on every transfer, reads and writes alike
  assign acc = apb.psel & apb.penable;
  assign wr_acc = acc & q.ack & apb.pwrite;

  // status byte shows the block's own live state
  // it is read-only: a write to its offset changes nothing
  always_comb begin
    stat = 8'h00;
    stat[STAT_LVL_LSB +: 3] = level;
    stat[STAT_PROG_BIT] = |prog_mask;
    stat[STAT_ERASE_BIT] = |erase_mask;
    stat[STAT_HWP_BIT] = hw_prot;
    stat[STAT_RDY_BIT] = settled;
  end

  // register read decode; unmapped offsets answer with an error
  // the full address is decoded, so no register has an alias
  always_comb begin
    hit = 1'b1;
    rd_word = 32'h0000_0000;
    case (apb.paddr)
      ADDR_MODE: rd_word = {24'h00_0000, q.mode};
      ADDR_BLK1: rd_word = {24'h00_0000, q.blk1};
      ADDR_BLK2: rd_word = {24'h00_0000, q.blk2};
      ADDR_STAT: rd_word = {24'h00_0000, stat};
      default: hit = 1'b0;
    endcase
  end

  // next state of every register
  always_comb begin
    d = q;
    d.ack = acc & !q.ack;
    if (acc & !q.ack) begin
      d.prdata = hit ? rd_word : 32'h0000_0000;
      d.slverr = !hit;
    end
    // writes land only at the edge that completes the transfer
    // bits above the mode field are dropped so they always read zero
    if (wr_acc) begin
      case (apb.paddr)
        ADDR_MODE: d.mode = apb.pwdata[7:0] & MODE_WMASK;
        ADDR_BLK1: d.blk1 = apb.pwdata[7:0];
        ADDR_BLK2: d.blk2 = apb.pwdata[7:0];
        default: d.mode = q.mode;
      endcase
    end
    // array data captured as read; the level is already on the cells
    if (flash_rd_req) begin
      d.rd_data = flash_cell_data;
    end
    // protection overrides any write in the same cycle
    // and repeats every cycle, so nothing set survives while it lasts
    if (hw_prot) begin
      d.mode = MODE_RST;
      d.blk1 = BLK1_RST;
      d.blk2 = BLK2_RST;
    end
  end

  // one register stage; async reset loads constants only
  // answer flops clear too, so no stale pready follows a reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q.mode <= MODE_RST;
      q.blk1 <= BLK1_RST;
      q.blk2 <= BLK2_RST;
      q.rd_data <= 8'h00;
      q.prdata <= 32'h0000_0000;
      q.slverr <= 1'b0;
      q.ack <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // enables are gated by the live protect term so work stops at once,
  // not one cycle later when the registers clear
  assign prog_blk = prog_mask;
  assign erase_blk = erase_mask;
  assign cell_level = level;
  assign hw_protect = hw_prot;
  assign pvv_ready = settled;
  assign rd_data = q.rd_data;
  assign prdata = q.prdata;
  assign pready = acc & q.ack;
  assign pslverr = acc & q.ack & q.slverr;

  // checks on the protection and mode logic
  // all of them are off while reset is asserted
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  hw_clear_a: assert property (
    hw_prot |=> q.mode == MODE_RST && q.blk1 == BLK1_RST
      && q.blk2 == BLK2_RST)
    else $error("registers not cleared under protection");

  hw_no_work_a: assert property (
    hw_prot |-> prog_blk == '0 && erase_blk == '0
      && cell_level == LVL_READ)
    else $error("program, erase or verify under protection");

  hw_erase_off_a: assert property (
    hw_prot ##1 hw_prot |-> erase_blk == '0 && q.blk2 == BLK2_RST)
    else $error("block selection active under protection");

  hw_ignore_wr_a: assert property (
    wr_acc && hw_prot && apb.paddr == ADDR_MODE |=> q.mode == MODE_RST)
    else $error("mode write taken under protection");

  all_prot_a: assert property (
    q.blk1 == ALL_PROT_BLK1 && q.blk2 == ALL_PROT_BLK2
      |-> prog_blk == '0 && erase_blk == '0)
    else $error("all-protect setting left a block open");

  sw_prot_a: assert property (
    !hw_prot && q.mode[MODE_P_BIT] && blk_en == '0 |-> prog_blk == '0
      && cell_level == LVL_PROG)
    else $error("protected program entered");

  prog_sel_a: assert property (
    !hw_prot && q.mode[MODE_P_BIT] |-> prog_blk == blk_en)
    else $error("program enables do not follow selects");

  verify_open_a: assert property (
    !hw_prot && q.mode[3:0] == 4'h4 && blk_en == '0
      |-> cell_level == LVL_PV)
    else $error("program-verify refused on protected blocks");

  prewrite_sel_a: assert property (
    !hw_prot && q.mode[3:0] == 4'h0 |-> cell_level == LVL_PREWRITE)
    else $error("prewrite-verify not selected with bits clear");

  read_data_a: assert property (
    flash_rd_req |=> rd_data == $past(flash_cell_data))
    else $error("read data not returned");

  mode_wr_a: assert property (
    wr_acc && !hw_prot && apb.paddr == ADDR_MODE
      |=> q.mode == ($past(apb.pwdata[7:0]) & MODE_WMASK))
    else $error("mode write lost");

  apb_wait_a: assert property (
    $rose(acc) |-> !pready ##1 pready)
    else $error("apb answer not in second access cycle");

  // answer shape, refused writes and the remaining enable decode
  ready_pulse_a: assert property (
    pready |=> !pready)
    else $error("pready held longer than one cycle");

  err_data_a: assert property (
    pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("error answer carried data");

  bad_wr_keep_a: assert property (
    pslverr && apb.pwrite && !hw_prot
      |=> q.mode == $past(q.mode) && q.blk1 == $past(q.blk1)
      && q.blk2 == $past(q.blk2))
    else $error("unmapped write changed a register");

  blk1_wr_a: assert property (
    wr_acc && !hw_prot && apb.paddr == ADDR_BLK1
      |=> q.blk1 == $past(apb.pwdata[7:0]))
    else $error("block select one write lost");

  blk2_wr_a: assert property (
    wr_acc && !hw_prot && apb.paddr == ADDR_BLK2
      |=> q.blk2 == $past(apb.pwdata[7:0]))
    else $error("block select two write lost");

  erase_sel_a: assert property (
    !hw_prot && !q.mode[MODE_P_BIT] && q.mode[MODE_E_BIT]
      |-> erase_blk == blk_en && prog_blk == '0)
    else $error("erase enables do not follow selects");

  one_job_a: assert property (
    !(|prog_blk && |erase_blk))
    else $error("program and erase enabled together");

  verify_idle_a: assert property (
    !q.mode[MODE_P_BIT] && !q.mode[MODE_E_BIT]
      |-> prog_blk == '0 && erase_blk == '0)
    else $error("verify mode drove a program or erase enable");

  verify_ev_a: assert property (
    !hw_prot && q.mode[3:0] == 4'h8
      |-> cell_level == LVL_EV)
    else $error("erase-verify not selected");

  erase_stop_a: assert property (
    |erase_blk ##1 hw_prot
      |-> erase_blk == '0 && cell_level == LVL_READ)
    else $error("erase in progress not stopped by protection");

  rd_hold_a: assert property (
    !flash_rd_req |=> rd_data == $past(rd_data))
    else $error("read data changed without a read");

  hw_status_a: assert property (
    hw_prot |-> hw_protect && !pvv_ready)
    else $error("protection not shown or settle flag left high");

  // scenarios worth seeing in a run
  settle_cov_c: cover property (
    cell_level == LVL_PREWRITE && pvv_ready && flash_rd_req);
  prog_cov_c: cover property (
    |prog_blk ##1 hw_prot);
  erase_cov_c: cover property (
    |erase_blk ##[1:4] !(|erase_blk));
  bad_addr_c: cover property (pslverr);
  hw_wr_c: cover property (wr_acc && hw_prot);

endmodule : fpv_flash_protect
`default_nettype wire

// ### test/fpv_flash_protect_tb.sv
// self-checking bench for the flash protect and prewrite-verify block
`timescale 1ns/1ps
`default_nettype none
module fpv_flash_protect_tb import fpv_pkg::*;;
  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] b1;
    logic [7:0] b2;
    fpv_level_t lvl;
    logic [11:0] p;
    logic [11:0] e;
  } fpv_row_t;

  logic clk = 1'b0;
  logic resetn = 1'b0;
  fpv_apb_req_t apb = '0;
  fpv_prot_in_t prot = 3'b100;
  logic flash_rd_req = 1'b0;
  logic [7:0] flash_cell_data = 8'h00;
  logic [31:0] prdata;
  logic pready, pslverr, hw_protect, pvv_ready;
  logic [7:0] rd_data;
  fpv_level_t cell_level;
  logic [11:0] prog_blk, erase_blk;
  int error_cnt = 0;
  int check_count = 0;
  logic [31:0] rv;
  logic re;
  fpv_row_t rows [8];

  // 40 MHz clock
  always #12.5 clk = ~clk;

  fpv_flash_protect dut_u (.clk(clk), .resetn(resetn), .apb(apb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .prot(prot),
    .flash_rd_req(flash_rd_req), .flash_cell_data(flash_cell_data),
    .rd_data(rd_data), .cell_level(cell_level), .prog_blk(prog_blk),
    .erase_blk(erase_blk), .hw_protect(hw_protect),
    .pvv_ready(pvv_ready));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : complete_run

  // one apb transfer; ends at the rising edge that samples pready high
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    apb <= '{1'b1, 1'b0, w, a, {24'h0, d}};
    @(posedge clk);
    apb.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      error_cnt++;
      complete_run();
    end
    rv = prdata;
    re = pslverr;
    apb <= '0;
  endtask : xfer

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 8'h00);
    check(rv, exp);
  endtask : rd

  // outputs are combinational, so look at them mid-cycle
  task automatic outs(input fpv_level_t l, input logic [11:0] p,
                      input logic [11:0] e);
    @(negedge clk);
    check({29'h0, cell_level}, {29'h0, l});
    check({20'h0, prog_blk}, {20'h0, p});
    check({20'h0, erase_blk}, {20'h0, e});
  endtask : outs

  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    complete_run();
  end

  initial begin
    rows = '{
      '{8'h00, 8'h0F, 8'hFF, LVL_PREWRITE, 12'h000, 12'h000},
      '{8'h01, 8'h05, 8'h00, LVL_PROG, 12'h005, 12'h000},
      '{8'h02, 8'h0A, 8'h81, LVL_ERASE, 12'h000, 12'h81A},
      '{8'hF4, 8'h0F, 8'hFF, LVL_PV, 12'h000, 12'h000},
      '{8'h08, 8'h0F, 8'hFF, LVL_EV, 12'h000, 12'h000},
      '{8'h01, 8'hF0, 8'h00, LVL_PROG, 12'h000, 12'h000},
      '{8'h02, 8'hF0, 8'h00, LVL_ERASE, 12'h000, 12'h000},
      '{8'h03, 8'h0F, 8'hFF, LVL_PROG, 12'hFFF, 12'h000}};
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    rd(ADDR_MODE, 32'h0);
    rd(ADDR_BLK1, 32'h0);
    rd(ADDR_BLK2, 32'h0);
    outs(LVL_PREWRITE, 12'h000, 12'h000);
    // mode and block select table
    foreach (rows[i]) begin
      xfer(1'b1, ADDR_BLK1, rows[i].b1);
      xfer(1'b1, ADDR_BLK2, rows[i].b2);
      xfer(1'b1, ADDR_MODE, rows[i].mode);
      rd(ADDR_MODE, {24'h0, rows[i].mode & MODE_WMASK});
      rd(ADDR_BLK1, {24'h0, rows[i].b1});
      outs(rows[i].lvl, rows[i].p, rows[i].e);
      xfer(1'b0, ADDR_STAT, 8'h00);
      check({26'h0, rv[5:0]}, {26'h0, 1'b0, |rows[i].e, |rows[i].p,
            rows[i].lvl});
    end
    // settle time after returning to prewrite-verify
    xfer(1'b1, ADDR_MODE, 8'h00);
    @(negedge clk);
    check({31'h0, pvv_ready}, 32'h0);
    repeat (159) @(negedge clk);
    check({31'h0, pvv_ready}, 32'h0);
    @(negedge clk);
    check({31'h0, pvv_ready}, 32'h1);
    @(posedge clk);
    flash_rd_req <= 1'b1;
    flash_cell_data <= 8'h5A;
    @(posedge clk);
    flash_rd_req <= 1'b0;
    flash_cell_data <= 8'hA5;
    @(negedge clk);
    check({24'h0, rd_data}, 32'h5A);
    // each protection source: no voltage, low power, watchdog reset
    for (int s = 0; s < 3; s++) begin
      xfer(1'b1, ADDR_BLK1, 8'h0F);
      xfer(1'b1, ADDR_BLK2, 8'hFF);
      xfer(1'b1, ADDR_MODE, 8'h02);
      outs(LVL_ERASE, 12'h000, 12'hFFF);
      @(posedge clk);
      prot <= (s == 0) ? 3'b000 : ((s == 1) ? 3'b110 : 3'b101);
      outs(LVL_READ, 12'h000, 12'h000);
      check({31'h0, hw_protect}, 32'h1);
      xfer(1'b1, ADDR_MODE, 8'h01);
      rd(ADDR_MODE, 32'h0);
      rd(ADDR_BLK2, 32'h0);
      outs(LVL_READ, 12'h000, 12'h000);
      @(posedge clk);
      prot <= 3'b100;
      rd(ADDR_BLK1, 32'h0);
      outs(LVL_PREWRITE, 12'h000, 12'h000);
    end
    // unmapped place refuses both directions
    xfer(1'b1, 12'h010, 8'h33);
    check({31'h0, re}, 32'h1);
    xfer(1'b0, 12'h010, 8'h00);
    check({re, rv[30:0]}, 32'h80000000);
    // reset in mid-run while erase is selected
    xfer(1'b1, ADDR_BLK2, 8'hFF);
    xfer(1'b1, ADDR_MODE, 8'h02);
    outs(LVL_ERASE, 12'h000, 12'hFF0);
    @(posedge clk);
    resetn <= 1'b0;
    repeat (10) @(posedge clk);
    check({20'h0, erase_blk}, 32'h0);
    resetn <= 1'b1;
    rd(ADDR_MODE, 32'h0);
    rd(ADDR_BLK2, 32'h0);
    complete_run();
  end
endmodule : fpv_flash_protect_tb
`default_nettype wire
